// ---- rtl/alarm_manager_defines.vh ----
`ifndef ALARM_MANAGER_DEFINES_VH
`define ALARM_MANAGER_DEFINES_VH

// ****************************************
// timing
// ****************************************
`define CLK_PERIOD_NS 32'h0000000A
`define MS_NS 32'h000F4240
`define BLINK_LAST_MS 12'h1F3
`define REFILL_HOLD_MS 12'h3E8
`define MAINT_HOLD_MS 12'hBB8

// ****************************************
// reagent
// ****************************************
`define LOW_ANALYSES 16'h0032
`define REAGENT_CAP_RST 16'h03E8

// ****************************************
// event codes
// ****************************************
`define CODE_PUMP1 7'h1E
`define CODE_PUMP2 7'h1F
`define CODE_LIGHT_ONE 7'h21
`define CODE_LIGHT_TWO 7'h1B
`define CODE_RECEIVER 7'h52
`define CODE_ZERO_MIN 7'h50
`define CODE_ZERO_MAX 7'h51
`define CODE_TURBID 7'h22
`define CODE_SOILED 7'h23
`define CODE_WATER_LOW 7'h26
`define CODE_EXT_LIGHT 7'h27
`define CODE_VENTING 7'h42
`define CODE_REAGENT_LOW 7'h25
`define CODE_RANGE 7'h0C
`define CODE_SERVICE 7'h0D
`define CODE_HEAD1 7'h19
`define CODE_HEAD2 7'h1A
`define CODE_DEPLETED 7'h7F

// ****************************************
// register map
// ****************************************
`define OFF_CTRL 8'h00
`define OFF_STATUS 8'h04
`define OFF_MASK 8'h08
`define OFF_STATE 8'h0C
`define OFF_REAGENT_CAP 8'h10
`define OFF_REAGENT_LEFT 8'h14
`define OFF_SERVICE_LIMIT 8'h18
`define OFF_PUMP_LIMIT 8'h1C
`define CTRL_RST 1'b1
`define STATUS_RST 8'h00
`define MASK_RST 8'h00
`define LIMIT_RST 16'h0000
`define HSIZE_WORD 3'b010

`endif

// ---- rtl/key_hold_timer.v ----
`timescale 1ns/100ps
module key_hold_timer #(
	parameter [11:0] HOLD_MS = 12'h3E8
) (
	input wire sys_clk,
	input wire rst,
	input wire msTick,
	input wire keyIn,
	output wire pressPulse,
	output wire holdPulse
);

	reg keyPrev_reg;
	reg [11:0] holdCnt_reg;
	reg fired_reg;

	// ****************************************
	// hold counting
	// ****************************************
	// tick phase is free running, so the pulse comes after more than HOLD_MS ms
	assign pressPulse = keyIn & ~keyPrev_reg;
	assign holdPulse = keyIn & (holdCnt_reg > HOLD_MS) & ~fired_reg; // (R16)

	always @(posedge sys_clk)
	begin
		if (rst)
		begin
			keyPrev_reg <= 1'b0;
			holdCnt_reg <= 12'h000;
			fired_reg <= 1'b0;
		end
		else
		begin
			keyPrev_reg <= keyIn;
			if (!keyIn)
			begin
				holdCnt_reg <= 12'h000;
				fired_reg <= 1'b0;
			end
			else
			begin
				if (msTick && holdCnt_reg != 12'hFFF)
					holdCnt_reg <= holdCnt_reg + 12'h001; // (R16)
				if (holdPulse)
					fired_reg <= 1'b1;
			end
		end
	end

endmodule

// ---- rtl/photometer_alarm_manager.v ----
`timescale 1ns/100ps
`include "alarm_manager_defines.vh"

// How it works
// (R1) pump, optics, turbidity, soiling, water, light, venting faults stop interval and abort
// (R2) reserve at ten percent raises code 37, interval keeps running
// (R3) range exceeded raises code 12 and stops interval operation
// (R4) optical faults kept apart: two light sources, receiver, two zero adjusts
// (R5) under 50 analyses: refill LED flashes, alarm key lit, relay switched, interval runs
// (R6) alarm key press clears low reagent alarm; refill LED keeps flashing
// (R7) depleted: refill and alarm keys lit, interval stopped, logged, relay switched
// (R8) refill key held over one second reloads reserve and clears depletion
// (R9) maintenance: yellow LED, interval continues, logged, relay untouched
// (R10) alarm key held three seconds then manual key resumes interval operation
// (R11) service interval expiry raises code 13; acknowledge restarts interval
// (R12) pump head run time raises 25 or 26; acknowledge restarts that counter
// (R13) alarm red and maintenance yellow shown together
// (R14) relay contact closed when fault free, open on fault or power loss
// (R15) stopping alarm blocks new measurements until acknowledged
// (R16) key holds timed on a millisecond tick against one and three seconds
module photometer_alarm_manager #(
	parameter TICK_CYCLES = `MS_NS / `CLK_PERIOD_NS
) (
	input wire sys_clk,
	input wire rst,
	input wire hsel,
	input wire [31:0] haddr,
	input wire [1:0] htrans,
	input wire hwrite,
	input wire [2:0] hsize,
	input wire [31:0] hwdata,
	input wire hready,
	output wire hreadyout,
	output wire hresp,
	output reg [31:0] hrdata,
	input wire faultValid,
	input wire [6:0] faultCode,
	input wire lightSourceOneFail,
	input wire lightSourceTwoFail,
	input wire opticalReceiverFail,
	input wire zeroMinFail,
	input wire zeroMaxFail,
	input wire analysisDone,
	input wire serviceTick,
	input wire pumpTick1,
	input wire pumpTick2,
	input wire alarmKey,
	input wire refillKey,
	input wire manualKey,
	output reg intervalRun,
	output reg abortMeas,
	output reg startBlock,
	output reg relayNoClosed,
	output reg alarmKeyRed,
	output reg refillLed,
	output reg refillConfirm,
	output reg maintLedYellow,
	output reg logValid,
	output reg [6:0] logCode,
	output reg irq
);

	localparam [31:0] TICK_FULL = TICK_CYCLES - 1;
	localparam [16:0] TICK_LAST = TICK_FULL[16:0];

	// ****************************************
	// functions
	// ****************************************
	function isStopCode;
		input [6:0] c;
		begin
			case (c)
				`CODE_PUMP1, `CODE_PUMP2, `CODE_LIGHT_ONE, `CODE_LIGHT_TWO,
				`CODE_RECEIVER, `CODE_ZERO_MIN, `CODE_ZERO_MAX, `CODE_TURBID,
				`CODE_SOILED, `CODE_WATER_LOW, `CODE_EXT_LIGHT, `CODE_VENTING:
					isStopCode = 1'b1;
				default:
					isStopCode = 1'b0;
			endcase
		end
	endfunction

	function [6:0] opticsCode;
		input [4:0] r;
		begin
			if (r[0])
				opticsCode = `CODE_LIGHT_ONE;
			else if (r[1])
				opticsCode = `CODE_LIGHT_TWO;
			else if (r[2])
				opticsCode = `CODE_RECEIVER;
			else if (r[3])
				opticsCode = `CODE_ZERO_MIN;
			else
				opticsCode = `CODE_ZERO_MAX;
		end
	endfunction

	// counters stop at the limit so a pending message cannot wrap away
	function [15:0] runCount;
		input [15:0] c;
		input [15:0] lim;
		input t;
		input restart;
		begin
			if (restart)
				runCount = 16'h0000;
			else if (t && c != lim)
				runCount = c + 16'h0001;
			else
				runCount = c;
		end
	endfunction

	function limitHit;
		input [15:0] c;
		input [15:0] lim;
		begin
			limitHit = (lim != 16'h0000) && (c == lim);
		end
	endfunction

	// ****************************************
	// millisecond tick and blink
	// ****************************************
	reg [16:0] tickCnt_reg;
	reg [11:0] blinkCnt_reg;
	reg blink_reg;
	wire msTick = (tickCnt_reg == TICK_LAST);

	always @(posedge sys_clk)
	begin
		if (rst)
		begin
			tickCnt_reg <= 17'h00000;
			blinkCnt_reg <= 12'h000;
			blink_reg <= 1'b0;
		end
		else
		begin
			tickCnt_reg <= msTick ? 17'h00000 : tickCnt_reg + 17'h00001; // (R16)
			if (msTick)
			begin
				blinkCnt_reg <= (blinkCnt_reg == `BLINK_LAST_MS) ? 12'h000 : blinkCnt_reg + 12'h001;
				if (blinkCnt_reg == `BLINK_LAST_MS)
					blink_reg <= ~blink_reg;
			end
		end
	end

	// ****************************************
	// keys
	// ****************************************
	wire alarmPress;
	wire alarmHold;
	wire refillHold;
	reg manualPrev_reg;
	wire manualPress = manualKey & ~manualPrev_reg;

	key_hold_timer #(.HOLD_MS(`MAINT_HOLD_MS)) alarmTimer (
		.sys_clk(sys_clk),
		.rst(rst),
		.msTick(msTick),
		.keyIn(alarmKey),
		.pressPulse(alarmPress),
		.holdPulse(alarmHold)
	);

	key_hold_timer #(.HOLD_MS(`REFILL_HOLD_MS)) refillTimer (
		.sys_clk(sys_clk),
		.rst(rst),
		.msTick(msTick),
		.keyIn(refillKey),
		.pressPulse(),
		.holdPulse(refillHold)
	);

	// ****************************************
	// bus slave
	// ****************************************
	reg wrPend_reg;
	reg [7:0] wrAddr_reg;
	reg ctrlEnable_reg;
	reg [7:0] status_reg;
	reg [7:0] mask_reg;
	reg [15:0] reagentCap_reg;
	reg [15:0] reagentLeft_reg;
	reg [15:0] serviceLimit_reg;
	reg [15:0] pumpLimit_reg;
	reg [31:0] rdata_next;
	wire addrPhase = hsel & htrans[1] & hready;
	wire wordAccess = (hsize == `HSIZE_WORD);

	assign hreadyout = 1'b1;
	assign hresp = 1'b0;

	// ****************************************
	// fault and maintenance state
	// ****************************************
	reg alarmActive_reg;
	reg lowAlarm_reg;
	reg stopLatch_reg;
	reg depleted_reg;
	reg maintPause_reg;
	reg maintSvc_reg;
	reg maintP1_reg;
	reg maintP2_reg;
	reg [4:0] optPrev_reg;
	reg [4:0] optLatch_reg;
	reg low10Prev_reg;
	reg low50Prev_reg;
	reg [6:0] lastCode_reg;
	reg [15:0] serviceCnt_reg;
	reg [15:0] pump1Cnt_reg;
	reg [15:0] pump2Cnt_reg;
	reg logValid_next;
	reg [6:0] logCode_next;

	wire [4:0] opt = {zeroMaxFail, zeroMinFail, opticalReceiverFail, lightSourceTwoFail,
		lightSourceOneFail};
	wire [4:0] optRise = opt & ~optPrev_reg; // (R4)
	wire extStop = faultValid & isStopCode(faultCode);
	wire stopEv = extStop | (|optRise); // (R1)
	wire rangeEv = faultValid & (faultCode == `CODE_RANGE); // (R3)
	wire [19:0] left10 = {1'b0, reagentLeft_reg, 3'b000} + {3'b000, reagentLeft_reg, 1'b0};
	wire low10 = (left10 <= {4'h0, reagentCap_reg});
	wire low50 = (reagentLeft_reg < `LOW_ANALYSES);
	wire low10Rise = low10 & ~low10Prev_reg; // (R2)
	wire low50Rise = low50 & ~low50Prev_reg; // (R5)
	wire emptyRise = (reagentLeft_reg == 16'h0000) & ~depleted_reg & ~refillHold; // (R7)
	wire svcNew = ~maintSvc_reg & limitHit(serviceCnt_reg, serviceLimit_reg); // (R11)
	wire p1New = ~maintP1_reg & limitHit(pump1Cnt_reg, pumpLimit_reg); // (R12)
	wire p2New = ~maintP2_reg & limitHit(pump2Cnt_reg, pumpLimit_reg); // (R12)
	wire maintAny = maintSvc_reg | maintP1_reg | maintP2_reg;
	wire maintAck = manualPress & maintPause_reg; // (R10)
	wire [7:0] events = {p2New, p1New, svcNew, emptyRise, low50Rise, low10Rise, rangeEv, stopEv};
	wire [7:0] statusClear = (wrPend_reg && wrAddr_reg == `OFF_STATUS) ? hwdata[7:0] : 8'h00;

	always @*
	begin
		case (haddr[7:0])
			`OFF_CTRL: rdata_next = {31'h00000000, ctrlEnable_reg};
			`OFF_STATUS: rdata_next = {24'h000000, status_reg};
			`OFF_MASK: rdata_next = {24'h000000, mask_reg};
			`OFF_STATE: rdata_next = {13'h0000, lastCode_reg, optLatch_reg, maintP2_reg,
				maintP1_reg, maintSvc_reg, maintPause_reg, depleted_reg, stopLatch_reg,
				alarmActive_reg | lowAlarm_reg};
			`OFF_REAGENT_CAP: rdata_next = {16'h0000, reagentCap_reg};
			`OFF_REAGENT_LEFT: rdata_next = {16'h0000, reagentLeft_reg};
			`OFF_SERVICE_LIMIT: rdata_next = {16'h0000, serviceLimit_reg};
			`OFF_PUMP_LIMIT: rdata_next = {16'h0000, pumpLimit_reg};
			default: rdata_next = 32'h00000000;
		endcase
	end

	// one event logged per cycle; a simultaneous lower one is dropped from the log
	always @*
	begin
		logValid_next = 1'b1;
		logCode_next = 7'h00;
		if (faultValid)
			logCode_next = faultCode;
		else if (|optRise)
			logCode_next = opticsCode(optRise);
		else if (emptyRise)
			logCode_next = `CODE_DEPLETED; // (R7)
		else if (low10Rise)
			logCode_next = `CODE_REAGENT_LOW; // (R2)
		else if (svcNew)
			logCode_next = `CODE_SERVICE; // (R9)
		else if (p1New)
			logCode_next = `CODE_HEAD1;
		else if (p2New)
			logCode_next = `CODE_HEAD2;
		else
			logValid_next = 1'b0;
	end

	always @(posedge sys_clk)
	begin
		if (rst)
		begin
			wrPend_reg <= 1'b0;
			wrAddr_reg <= 8'h00;
			hrdata <= 32'h00000000;
			ctrlEnable_reg <= `CTRL_RST;
			status_reg <= `STATUS_RST;
			mask_reg <= `MASK_RST;
			reagentCap_reg <= `REAGENT_CAP_RST;
			reagentLeft_reg <= `REAGENT_CAP_RST;
			serviceLimit_reg <= `LIMIT_RST;
			pumpLimit_reg <= `LIMIT_RST;
			manualPrev_reg <= 1'b0;
			alarmActive_reg <= 1'b0;
			lowAlarm_reg <= 1'b0;
			stopLatch_reg <= 1'b0;
			depleted_reg <= 1'b0;
			maintPause_reg <= 1'b0;
			maintSvc_reg <= 1'b0;
			maintP1_reg <= 1'b0;
			maintP2_reg <= 1'b0;
			optPrev_reg <= 5'h00;
			optLatch_reg <= 5'h00;
			low10Prev_reg <= 1'b0;
			low50Prev_reg <= 1'b0;
			lastCode_reg <= 7'h00;
			serviceCnt_reg <= 16'h0000;
			pump1Cnt_reg <= 16'h0000;
			pump2Cnt_reg <= 16'h0000;
			intervalRun <= 1'b0;
			abortMeas <= 1'b0;
			startBlock <= 1'b0;
			relayNoClosed <= 1'b0;
			alarmKeyRed <= 1'b0;
			refillLed <= 1'b0;
			refillConfirm <= 1'b0;
			maintLedYellow <= 1'b0;
			logValid <= 1'b0;
			logCode <= 7'h00;
			irq <= 1'b0;
		end
		else
		begin
			wrPend_reg <= addrPhase & hwrite & wordAccess;
			if (addrPhase)
				wrAddr_reg <= haddr[7:0];
			if (addrPhase && !hwrite)
				hrdata <= rdata_next;
			if (wrPend_reg)
			begin
				case (wrAddr_reg)
					`OFF_CTRL: ctrlEnable_reg <= hwdata[0];
					`OFF_MASK: mask_reg <= hwdata[7:0];
					`OFF_REAGENT_CAP: reagentCap_reg <= hwdata[15:0];
					`OFF_SERVICE_LIMIT: serviceLimit_reg <= hwdata[15:0];
					`OFF_PUMP_LIMIT: pumpLimit_reg <= hwdata[15:0];
					default: ;
				endcase
			end
			// set wins over a write-one clear in the same cycle
			status_reg <= (status_reg & ~statusClear) | events;
			irq <= |(((status_reg & ~statusClear) | events) & mask_reg);
			manualPrev_reg <= manualKey;
			optPrev_reg <= opt;
			low10Prev_reg <= low10;
			low50Prev_reg <= low50;
			if (refillHold)
				reagentLeft_reg <= reagentCap_reg; // (R8)
			else if (analysisDone && reagentLeft_reg != 16'h0000)
				reagentLeft_reg <= reagentLeft_reg - 16'h0001;
			alarmActive_reg <= stopEv | rangeEv | (alarmActive_reg & ~alarmPress);
			stopLatch_reg <= stopEv | rangeEv | (stopLatch_reg & ~alarmPress); // (R15)
			optLatch_reg <= optRise | (optLatch_reg & {5{~alarmPress}}); // (R4)
			lowAlarm_reg <= low50Rise | (lowAlarm_reg & ~alarmPress & ~refillHold); // (R6)
			depleted_reg <= emptyRise | (depleted_reg & ~refillHold); // (R8)
			if (logValid_next)
				lastCode_reg <= logCode_next;
			maintSvc_reg <= svcNew | (maintSvc_reg & ~maintAck);
			maintP1_reg <= p1New | (maintP1_reg & ~maintAck);
			maintP2_reg <= p2New | (maintP2_reg & ~maintAck);
			maintPause_reg <= (alarmHold & maintAny) | (maintPause_reg & ~maintAck); // (R10)
			serviceCnt_reg <= runCount(serviceCnt_reg, serviceLimit_reg, serviceTick,
				maintAck & maintSvc_reg); // (R11)
			pump1Cnt_reg <= runCount(pump1Cnt_reg, pumpLimit_reg, pumpTick1,
				maintAck & maintP1_reg); // (R12)
			pump2Cnt_reg <= runCount(pump2Cnt_reg, pumpLimit_reg, pumpTick2,
				maintAck & maintP2_reg); // (R12)
			// low reagent, code 37 and maintenance leave interval operation running
			intervalRun <= ctrlEnable_reg & ~stopLatch_reg & ~depleted_reg
				& ~maintPause_reg; // (R2) (R5) (R9)
			abortMeas <= stopEv; // (R1)
			startBlock <= stopLatch_reg | depleted_reg; // (R15)
			// maintenance alone keeps the contact closed
			relayNoClosed <= ~(alarmActive_reg | lowAlarm_reg | depleted_reg); // (R14)
			alarmKeyRed <= alarmActive_reg | lowAlarm_reg | depleted_reg; // (R13)
			refillLed <= depleted_reg | (low50 & blink_reg); // (R5) (R7)
			refillConfirm <= refillHold | (refillConfirm & refillKey);
			maintLedYellow <= maintAny; // (R9) (R13)
			logValid <= logValid_next;
			if (logValid_next)
				logCode <= logCode_next;
		end
	end

endmodule

// ---- verification/photometer_alarm_manager_chk.sv ----
`timescale 1ns/100ps
module photometer_alarm_manager_chk (
	input wire sys_clk,
	input wire rst,
	input wire faultValid,
	input wire [6:0] faultCode,
	input wire lightSourceOneFail,
	input wire opticalReceiverFail,
	input wire alarmKey,
	input wire abortMeas,
	input wire logValid,
	input wire [6:0] logCode,
	input wire intervalRun,
	input wire startBlock,
	input wire relayNoClosed
);
	// ****************
	// properties
	// ****************
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (rst);
	wire stopCode = faultValid && (faultCode == 7'h1E || faultCode == 7'h1F || faultCode == 7'h22);
	property p_stop_abort;
		stopCode |=> abortMeas && logValid && logCode == $past(faultCode);
	endproperty
	a_stop_abort: assert property (p_stop_abort) else $error("stop fault not aborted");
	// an ack press may clear the stop, so keep it out
	property p_stop_run;
		stopCode && !alarmKey ##1 !alarmKey |=> !intervalRun && !relayNoClosed;
	endproperty
	a_stop_run: assert property (p_stop_run) else $error("interval not stopped");
	property p_block;
		stopCode && !alarmKey ##1 !alarmKey |=> startBlock;
	endproperty
	a_block: assert property (p_block) else $error("start not blocked");
	property p_range;
		faultValid && faultCode == 7'h0C && !alarmKey |=> !abortMeas ##1 !intervalRun;
	endproperty
	a_range: assert property (p_range) else $error("range fault handling wrong");
	property p_optic;
		$rose(lightSourceOneFail) && !faultValid |=> logValid && logCode == 7'h21;
	endproperty
	a_optic: assert property (p_optic) else $error("light source fault code wrong");
	property p_receiver;
		$rose(opticalReceiverFail) && !faultValid |=> abortMeas && logCode == 7'h52;
	endproperty
	a_receiver: assert property (p_receiver) else $error("receiver fault code wrong");
	property p_relay_rst;
		disable iff (1'b0) rst |=> !relayNoClosed && !intervalRun;
	endproperty
	a_relay_rst: assert property (p_relay_rst) else $error("relay closed in reset");
	property p_relay_up;
		$fell(rst) |-> ##[1:3] relayNoClosed;
	endproperty
	a_relay_up: assert property (p_relay_up) else $error("relay not closed");
endmodule
bind photometer_alarm_manager photometer_alarm_manager_chk u_chk (.sys_clk, .rst, .faultValid,
	.faultCode, .lightSourceOneFail, .opticalReceiverFail, .alarmKey, .abortMeas, .logValid,
	.logCode, .intervalRun, .startBlock, .relayNoClosed);

// ---- verification/master_controller_model.sv ----
`timescale 1ns/100ps
module master_controller_model (
	input wire sys_clk,
	input wire relayNoClosed,
	output logic faultReported
);
	// ****************
	// alarm input
	// ****************
	// open contact reads as fault, so power loss reports too
	always @(posedge sys_clk)
		faultReported <= !relayNoClosed;
endmodule

// ---- verification/tb_top.sv ----
`timescale 1ns/100ps
module tb_top;
	// ****************
	// stimulus
	// ****************
	logic sys_clk = 0, rst = 1, hsel = 0, hwrite = 0, faultValid = 0;
	logic alarmKey = 0, refillKey = 0, manualKey = 0;
	logic [31:0] haddr = 0, hwdata = 0, rd;
	logic [1:0] htrans = 0;
	logic [2:0] hsize = 3'h2;
	logic [6:0] faultCode = 0;
	logic [4:0] optics = 0;
	logic [3:0] ticks = 0;
	wire hreadyout, hresp, intervalRun, abortMeas, startBlock, relayNoClosed, alarmKeyRed;
	wire refillLed, refillConfirm, maintLedYellow, logValid, irq, faultReported;
	wire [31:0] hrdata;
	wire [6:0] logCode;
	wire [5:0] outs = {intervalRun, relayNoClosed, alarmKeyRed, startBlock, maintLedYellow, irq};
	integer seed = 3, errorCnt = 0, nTests = 0, cyc = 0, i, hi;
	localparam logic [6:0] STOPS [0:6] = '{7'h1E, 7'h1F, 7'h22, 7'h23, 7'h26, 7'h27, 7'h42};
	localparam logic [6:0] OPT [0:4] = '{7'h21, 7'h1B, 7'h52, 7'h50, 7'h51};
	localparam logic [7:0] RA [0:4] = '{8'h00, 8'h08, 8'h10, 8'h14, 8'h40};
	localparam logic [31:0] RV [0:4] = '{32'h1, 32'h0, 32'h3E8, 32'h3E8, 32'h0};
	always #5 sys_clk = ~sys_clk;
	photometer_alarm_manager #(.TICK_CYCLES(10)) u_photometer_alarm_manager (.sys_clk, .rst,
		.hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout), .hreadyout, .hresp,
		.hrdata, .faultValid, .faultCode, .lightSourceOneFail(optics[0]),
		.lightSourceTwoFail(optics[1]), .opticalReceiverFail(optics[2]), .zeroMinFail(optics[3]),
		.zeroMaxFail(optics[4]), .analysisDone(ticks[0]), .serviceTick(ticks[1]),
		.pumpTick1(ticks[2]), .pumpTick2(ticks[3]), .alarmKey, .refillKey, .manualKey,
		.intervalRun, .abortMeas, .startBlock, .relayNoClosed, .alarmKeyRed, .refillLed,
		.refillConfirm, .maintLedYellow, .logValid, .logCode, .irq);
	master_controller_model u_master_controller_model (.sys_clk, .relayNoClosed, .faultReported);
	// ****************
	// tasks
	// ****************
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		nTests++;
		if (seen !== exp)
		begin
			errorCnt++;
			$display("unexpected %s: expected %h seen %h", nm, exp, seen);
		end
	endtask
	function automatic logic [6:0] expCode(input integer n);
		return n < 7 ? STOPS[n] : OPT[n - 7];
	endfunction
	task automatic stopTest();
		$display("comparisons %0d mismatches %0d", nTests, errorCnt);
		if (errorCnt == 0 && nTests > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task automatic clk(input integer n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		hsel <= 1;
		htrans <= 2'h2;
		hwrite <= w;
		haddr <= {24'h0, a};
		do @(posedge sys_clk); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge sys_clk); while (hreadyout !== 1'b1);
		rd = hrdata;
	endtask
	task automatic fault(input logic [6:0] c);
		@(posedge sys_clk);
		faultValid <= 1;
		faultCode <= c;
		@(posedge sys_clk);
		faultValid <= 0;
		#1;
	endtask
	task automatic key(input integer n);
		@(posedge sys_clk);
		alarmKey <= 1;
		repeat (n) @(posedge sys_clk);
		alarmKey <= 0;
		clk(3);
	endtask
	// random gaps shake the event spacing
	task automatic pulses(input integer n, input integer k);
		repeat (n)
		begin
			@(posedge sys_clk);
			ticks[k] <= 1;
			@(posedge sys_clk);
			ticks <= 0;
			repeat ({$random(seed)} % 4) @(posedge sys_clk);
		end
		clk(3);
	endtask
	task automatic refill();
		@(posedge sys_clk);
		refillKey <= 1;
		clk(10100);
		chk("refillConfirm", refillConfirm, 1);
		@(posedge sys_clk);
		refillKey <= 0;
		clk(4);
	endtask
	always @(posedge sys_clk)
	begin
		cyc++;
		if (cyc > 80000)
		begin
			errorCnt++;
			stopTest();
		end
	end
	// ****************
	// sequence
	// ****************
	initial
	begin
		clk(10);
		chk("outs", outs, 0);
		@(posedge sys_clk);
		rst <= 0;
		clk(3);
		chk("outs", outs, 6'h30);
		for (i = 0; i < 5; i++)
		begin
			bus(0, RA[i], 0);
			chk("reg", rd, RV[i]);
		end
		chk("hresp", hresp, 0);
		hi = $random(seed);
		bus(1, 8'h08, hi);
		bus(0, 8'h08, 0);
		chk("mask", rd, hi & 32'hFF);
		bus(1, 8'h08, 0);
		bus(1, 8'h14, 5);
		bus(0, 8'h14, 0);
		chk("left", rd, 32'h3E8);
		$display("registers done");
		for (i = 0; i < 12; i++)
		begin
			if (i < 7)
				fault(STOPS[i]);
			else
			begin
				@(posedge sys_clk);
				optics[i - 7] <= 1;
				clk(1);
			end
			chk("abort", abortMeas, 1);
			chk("logValid", logValid, 1);
			chk("logCode", logCode, expCode(i));
			clk(1);
			chk("outs", outs, 6'h0C);
			clk(1);
			chk("master", faultReported, 1);
			@(posedge sys_clk);
			optics <= 0;
			key(2);
			chk("outs", outs, 6'h30);
			chk("master", faultReported, 0);
			bus(1, 8'h04, 32'hFF);
		end
		fault(7'h0C);
		chk("abort", abortMeas, 0);
		clk(1);
		chk("run", intervalRun, 0);
		key(2);
		bus(1, 8'h08, 1);
		fault(7'h1E);
		clk(1);
		chk("outs", outs, 6'h0D);
		key(2);
		bus(1, 8'h04, 1);
		clk(2);
		chk("irq", irq, 0);
		bus(1, 8'h08, 0);
		$display("faults done");
		bus(1, 8'h18, 3);
		bus(1, 8'h1C, 2);
		pulses(3, 1);
		pulses(2, 2);
		pulses(2, 3);
		chk("outs", outs, 6'h32);
		bus(0, 8'h04, 0);
		chk("status", rd, 32'hE2);
		fault(7'h1E);
		clk(1);
		chk("outs", outs, 6'h0E);
		key(31000);
		chk("run", intervalRun, 0);
		@(posedge sys_clk);
		manualKey <= 1;
		@(posedge sys_clk);
		manualKey <= 0;
		clk(3);
		chk("outs", outs, 6'h30);
		pulses(2, 1);
		chk("yellow", maintLedYellow, 0);
		pulses(1, 1);
		chk("yellow", maintLedYellow, 1);
		$display("maintenance done");
		bus(1, 8'h10, 32'h3C);
		refill();
		bus(0, 8'h14, 0);
		chk("left", rd, 32'h3C);
		pulses(11, 0);
		chk("outs", outs, 6'h2A);
		key(2);
		chk("red", alarmKeyRed, 0);
		hi = 0;
		repeat (10000) @(negedge sys_clk) hi += refillLed;
		chk("blink", hi > 0 && hi < 10000, 1);
		pulses(43, 0);
		bus(0, 8'h04, 0);
		chk("status", rd & 32'h0C, 32'h0C);
		chk("run", intervalRun, 1);
		pulses(6, 0);
		chk("outs", outs & 6'h3A, 6'h0A);
		chk("led", refillLed, 1);
		bus(0, 8'h0C, 0);
		chk("logged", rd[18:12], 7'h7F);
		refill();
		chk("outs", outs & 6'h38, 6'h30);
		$display("reagent done");
		stopTest();
	end
endmodule
